/* rtl/pso_pkg.sv */
// package with constants for the privileged state operations unit
// How it works
// - every operation checks status mode; user mode raises the reserved-instruction fault
// - read-status copies the whole status word into the result, nothing else changes
// - read-user-stack returns the saved user stack pointer in the result
// - read-system-value returns the 64-bit per-processor system value register
// - system-call return pops return address (+8), global pointer (+16), kernel sp = sp+48
// - system-call return restores user sp, status becomes 8, jumps to popped address
// - both returns clear the pending-interrupt and load-locked flags unless a new set arrives in the same cycle
// - exception return pops status, pc, gp, a0..a2 from offsets 0..40, sp += 48
// - popped status bit 3 set: save kernel sp, take user sp, status 8; load bits 3:0
// - invalid kernel stack at a return request halts the processor before any frame pop
// - context swap saves sp at +0, user sp at +8, returns old base, adopts a0
// - context swap loads sp, user sp, page table base, float enable from new block
// - context swap saves counter low+high at +24, sets counter high to new low minus sample
// - with unique register, context swap stores it at old +32 and reloads new +32
// - with address-space numbers load from +24 high word, else flush non-global on base change
// - swap-priority returns the priority field and loads a0 bits 2:0
// - invalidate decodes a0: 1,2,3 single entries, -1 non-global, -2 all, else nothing
// - processor-number query returns this processor index, 0 to count minus one
// - reserved operations and user-mode privileged attempts take the reserved-instruction fault
package pso_pkg;
  // function codes of the operations
  localparam logic [5:0] PSO_FN_RDPS    = 6'h00;
  localparam logic [5:0] PSO_FN_RDUSP   = 6'h01;
  localparam logic [5:0] PSO_FN_RDVAL   = 6'h02;
  localparam logic [5:0] PSO_FN_RETSYS  = 6'h03;
  localparam logic [5:0] PSO_FN_RTI     = 6'h04;
  localparam logic [5:0] PSO_FN_SWPCTX  = 6'h05;
  localparam logic [5:0] PSO_FN_SWPIPL  = 6'h06;
  localparam logic [5:0] PSO_FN_TBI     = 6'h07;
  localparam logic [5:0] PSO_FN_WHAMI   = 6'h08;
  // status word fields
  localparam int          PSO_PS_MODE_BIT = 3;
  localparam logic [63:0] PSO_PS_USER     = 64'h0000_0000_0000_0008;
  localparam logic [63:0] PSO_PS_RESET    = 64'h0000_0000_0000_0007;
  // stack frame and control block offsets
  localparam logic [63:0] PSO_OFS_0     = 64'h00;
  localparam logic [63:0] PSO_OFS_8     = 64'h08;
  localparam logic [63:0] PSO_OFS_16    = 64'h10;
  localparam logic [63:0] PSO_OFS_24    = 64'h18;
  localparam logic [63:0] PSO_OFS_32    = 64'h20;
  localparam logic [63:0] PSO_OFS_40    = 64'h28;
  localparam logic [63:0] PSO_FRAME_LEN = 64'h30;
  // invalidate selector codes
  localparam logic [63:0] PSO_TBI_I    = 64'h1;
  localparam logic [63:0] PSO_TBI_D    = 64'h2;
  localparam logic [63:0] PSO_TBI_BOTH = 64'h3;
  localparam logic [63:0] PSO_TBI_NG   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] PSO_TBI_ALL  = 64'hFFFF_FFFF_FFFF_FFFE;
  // translation invalidate command encoding on the tb port
  localparam logic [2:0] PSO_TBC_NONE = 3'h0;
  localparam logic [2:0] PSO_TBC_I    = 3'h1;
  localparam logic [2:0] PSO_TBC_D    = 3'h2;
  localparam logic [2:0] PSO_TBC_BOTH = 3'h3;
  localparam logic [2:0] PSO_TBC_NG   = 3'h4;
  localparam logic [2:0] PSO_TBC_ALL  = 3'h5;
  // apb register map
  localparam logic [11:0] PSO_REG_CTRL   = 12'h000;
  localparam logic [11:0] PSO_REG_STATUS = 12'h004;
  localparam logic [11:0] PSO_REG_PS     = 12'h008;
  localparam logic [11:0] PSO_REG_SYSVAL_LO = 12'h00C;
  localparam logic [11:0] PSO_REG_SYSVAL_HI = 12'h010;
  localparam logic [11:0] PSO_REG_USP_LO = 12'h014;
  localparam logic [11:0] PSO_REG_CONTROL_BLOCK_BASE_LO = 12'h018;
  localparam logic [11:0] PSO_REG_PAGE_TABLE_BASE_LO = 12'h01C;
  localparam logic [11:0] PSO_REG_IPL    = 12'h020;
endpackage

/* rtl/pso_apb_regs.sv */
// apb slave holding the software-visible control and status of the unit
`timescale 1ns/10ps
`default_nettype none
module pso_apb_regs
  import pso_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // unit state
  input  wire logic [63:0] ps_i,
  input  wire logic [63:0] usp_i,
  input  wire logic [63:0] control_block_base_i,
  input  wire logic [63:0] page_table_base_i,
  input  wire logic [7:0]  status_i,
  output logic      [63:0] sysval_o,
  output logic             kstack_ok_o,
  output logic             asn_en_o,
  output logic             uniq_en_o
);
  logic acc;
  logic hit;
  assign acc      = psel_i & penable_i;
  assign pready_o = 1'b1; // zero wait states
  // address decode, unmapped addresses error
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      PSO_REG_CTRL:      prdata_o = {29'h0, uniq_en_o, asn_en_o, kstack_ok_o};
      PSO_REG_STATUS:    prdata_o = {24'h0, status_i};
      PSO_REG_PS:        prdata_o = ps_i[31:0];
      PSO_REG_SYSVAL_LO: prdata_o = sysval_o[31:0];
      PSO_REG_SYSVAL_HI: prdata_o = sysval_o[63:32];
      PSO_REG_USP_LO:    prdata_o = usp_i[31:0];
      PSO_REG_CONTROL_BLOCK_BASE_LO:   prdata_o = control_block_base_i[31:0];
      PSO_REG_PAGE_TABLE_BASE_LO:   prdata_o = page_table_base_i[31:0];
      PSO_REG_IPL:       prdata_o = {29'h0, ps_i[2:0]};
      default: begin
        prdata_o = 32'h0;
        hit      = 1'b0;
      end
    endcase
  end
  assign pslverr_o = acc & ~hit;
  // writable control: stack valid, optional features, system value
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      kstack_ok_o <= 1'b1;
      asn_en_o    <= 1'b0;
      uniq_en_o   <= 1'b1;
      sysval_o    <= 64'h0;
    end else if (acc & pwrite_i) begin
      if (paddr_i == PSO_REG_CTRL) begin
        kstack_ok_o <= pwdata_i[0];
        asn_en_o    <= pwdata_i[1];
        uniq_en_o   <= pwdata_i[2];
      end
      if (paddr_i == PSO_REG_SYSVAL_LO) sysval_o[31:0] <= pwdata_i;
      if (paddr_i == PSO_REG_SYSVAL_HI) sysval_o[63:32] <= pwdata_i;
    end
  end
endmodule
`default_nettype wire

/* rtl/pso_unit.sv */
// privileged state operation sequencer with memory port and apb control
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module pso_unit
  import pso_pkg::*;
#(
  parameter logic [7:0] CPU_INDEX = 8'h00
)(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // operation request
  input  wire logic        op_valid_i,
  input  wire logic [5:0]  op_func_i,
  input  wire logic [63:0] sp_i,
  input  wire logic [63:0] a0_i,
  input  wire logic [63:0] a1_i,
  input  wire logic [63:0] a2_i,
  input  wire logic [63:0] gp_i,
  output logic             op_ready_o,
  output logic             op_done_o,
  output logic             fault_o,
  output logic             halt_o,
  // results
  output logic      [63:0] v0_o,
  output logic      [63:0] sp_o,
  output logic      [63:0] gp_o,
  output logic      [63:0] a0_o,
  output logic      [63:0] a1_o,
  output logic      [63:0] a2_o,
  output logic      [63:0] pc_o,
  output logic      [6:0]  wb_mask_o,
  // processor state
  output logic      [63:0] ps_o,
  output logic             intr_flag_o,
  output logic             lock_flag_o,
  output logic             fen_o,
  output logic      [31:0] asn_o,
  input  wire logic        intr_set_i,
  input  wire logic        lock_set_i,
  // memory port
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [63:0] mem_addr_o,
  output logic      [63:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [63:0] mem_rdata_i,
  // translation buffer
  output logic      [2:0]  tb_cmd_o,
  output logic      [63:0] tb_va_o,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  typedef enum logic [2:0] {
    PSO_IDLE, PSO_MEM, PSO_FINISH, PSO_HALTED
  } pso_state_e;

  pso_state_e  state_q;
  logic [5:0]  func_q;
  logic [3:0]  step_q;
  logic [63:0] sp_q, a0_q, a1_q, gp_q;
  logic [63:0] usp_q, control_block_base_q, page_table_base_q, old_page_table_base_q, uniq_q, cyc_q, cyc_smp_q, tmp_q;
  logic [63:0] ps_q;
  logic [63:0] sysval;
  logic        kstack_ok, asn_en, uniq_en;
  logic [7:0]  status_q;
  logic        start, is_priv, user_mode, last_step;
  logic [63:0] rd;

  // byte address helper, used by every frame and block access
  function automatic logic [63:0] pso_addr(input logic [63:0] base, input logic [63:0] ofs);
    pso_addr = base + ofs;
  endfunction

  assign ps_o       = ps_q;
  assign user_mode  = ps_q[PSO_PS_MODE_BIT];
  assign op_ready_o = (state_q == PSO_IDLE);
  assign start      = op_valid_i & op_ready_o;
  assign rd         = mem_rdata_i;
  // reserved codes are not privileged ops
  assign is_priv    = (op_func_i <= PSO_FN_WHAMI);

  // memory access plan per operation and step
  always_comb begin
    mem_we_o    = 1'b0;
    mem_addr_o  = 64'h0;
    mem_wdata_o = 64'h0;
    last_step   = 1'b1;
    case (func_q)
      PSO_FN_RETSYS: begin
        mem_addr_o = pso_addr(sp_q, (step_q == 4'd0) ? PSO_OFS_8 : PSO_OFS_16);
        last_step  = (step_q == 4'd1);
      end
      PSO_FN_RTI: begin
        mem_addr_o = pso_addr(sp_q, {58'h0, step_q[2:0], 3'h0});
        last_step  = (step_q == 4'd5);
      end
      PSO_FN_SWPCTX: begin
        // old block is handled first (steps 0-4, step 2 reads +24), then the new block is read (5-10)
        last_step = (step_q == 4'd10);
        case (step_q)
          4'd0: begin mem_we_o = 1'b1; mem_addr_o = pso_addr(control_block_base_q, PSO_OFS_0); mem_wdata_o = sp_q; end
          4'd1: begin mem_we_o = 1'b1; mem_addr_o = pso_addr(control_block_base_q, PSO_OFS_8); mem_wdata_o = usp_q; end
          4'd2: begin mem_addr_o = pso_addr(control_block_base_q, PSO_OFS_24); end
          4'd3: begin
            mem_we_o    = 1'b1;
            mem_addr_o  = pso_addr(control_block_base_q, PSO_OFS_24);
            mem_wdata_o = {tmp_q[63:32], cyc_smp_q[31:0] + cyc_smp_q[63:32]};
          end
          4'd4: begin mem_we_o = uniq_en; mem_addr_o = pso_addr(control_block_base_q, PSO_OFS_32); mem_wdata_o = uniq_q; end
          4'd5: mem_addr_o = pso_addr(a0_q, PSO_OFS_0);
          4'd6: mem_addr_o = pso_addr(a0_q, PSO_OFS_8);
          4'd7: mem_addr_o = pso_addr(a0_q, PSO_OFS_16);
          4'd8: mem_addr_o = pso_addr(a0_q, PSO_OFS_24);
          4'd9: mem_addr_o = pso_addr(a0_q, PSO_OFS_40);
          // unique reload comes last so the save above can never read the new block
          default: mem_addr_o = pso_addr(a0_q, PSO_OFS_32);
        endcase
      end
      default: ;
    endcase
  end

  // sequencer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= PSO_IDLE;
      func_q  <= 6'h0;
      step_q  <= 4'h0;
    end else begin
      case (state_q)
        PSO_IDLE: if (start) begin
          func_q <= op_func_i;
          step_q <= 4'h0;
          if (!is_priv || user_mode) state_q <= PSO_FINISH;
          else if (op_func_i inside {PSO_FN_RETSYS, PSO_FN_RTI, PSO_FN_SWPCTX}) begin
            if (op_func_i != PSO_FN_SWPCTX && !kstack_ok) state_q <= PSO_HALTED;
            else state_q <= PSO_MEM;
          end else state_q <= PSO_FINISH;
        end
        PSO_MEM: if (mem_ack_i) begin
          step_q <= step_q + 4'h1;
          if (last_step) state_q <= PSO_FINISH;
        end
        PSO_FINISH: state_q <= PSO_IDLE;
        PSO_HALTED: state_q <= PSO_HALTED;
        default: state_q <= PSO_IDLE;
      endcase
    end
  end
  assign mem_req_o = (state_q == PSO_MEM);
  assign halt_o    = (state_q == PSO_HALTED);

  // operand capture and popped values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sp_q <= 64'h0; a0_q <= 64'h0; a1_q <= 64'h0; gp_q <= 64'h0; tmp_q <= 64'h0;
    end else if (start) begin
      sp_q <= sp_i; a0_q <= a0_i; a1_q <= a1_i; gp_q <= gp_i;
    end else if (mem_req_o & mem_ack_i & ~mem_we_o) begin
      if (func_q == PSO_FN_RETSYS && step_q == 4'd0) tmp_q <= rd; // return address
      if (func_q == PSO_FN_RTI && step_q == 4'd0) tmp_q <= rd;     // saved status
      if (func_q == PSO_FN_SWPCTX && step_q == 4'd2) tmp_q <= rd;  // keep high word of +24
    end
  end

  // architectural outputs, written as memory reads return and on the finishing step
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      v0_o <= 64'h0; sp_o <= 64'h0; gp_o <= 64'h0; pc_o <= 64'h0;
      a0_o <= 64'h0; a1_o <= 64'h0; a2_o <= 64'h0;
      wb_mask_o <= 7'h0; op_done_o <= 1'b0; fault_o <= 1'b0;
    end else begin
      op_done_o <= 1'b0;
      fault_o   <= 1'b0;
      if (start) wb_mask_o <= 7'h0;
      if (mem_req_o & mem_ack_i & ~mem_we_o) begin
        case (func_q)
          PSO_FN_RETSYS: if (step_q == 4'd1) begin gp_o <= rd; wb_mask_o[2] <= 1'b1; end
          PSO_FN_RTI: case (step_q)
            4'd1: begin pc_o <= rd; wb_mask_o[6] <= 1'b1; end
            4'd2: begin gp_o <= rd; wb_mask_o[2] <= 1'b1; end
            4'd3: begin a0_o <= rd; wb_mask_o[3] <= 1'b1; end
            4'd4: begin a1_o <= rd; wb_mask_o[4] <= 1'b1; end
            4'd5: begin a2_o <= rd; wb_mask_o[5] <= 1'b1; end
            default: ;
          endcase
          PSO_FN_SWPCTX: if (step_q == 4'd5) begin sp_o <= rd; wb_mask_o[1] <= 1'b1; end
          default: ;
        endcase
      end
      if (state_q == PSO_FINISH) begin
        op_done_o <= 1'b1;
        if (!(func_q <= PSO_FN_WHAMI) || user_mode) fault_o <= 1'b1;
        else begin
          case (func_q)
            PSO_FN_RDPS:   begin v0_o <= ps_q; wb_mask_o[0] <= 1'b1; end
            PSO_FN_RDUSP:  begin v0_o <= usp_q; wb_mask_o[0] <= 1'b1; end
            PSO_FN_RDVAL:  begin v0_o <= sysval; wb_mask_o[0] <= 1'b1; end
            PSO_FN_WHAMI:  begin v0_o <= {56'h0, CPU_INDEX}; wb_mask_o[0] <= 1'b1; end
            PSO_FN_SWPIPL: begin v0_o <= {61'h0, ps_q[2:0]}; wb_mask_o[0] <= 1'b1; end
            PSO_FN_SWPCTX: begin v0_o <= control_block_base_q; wb_mask_o[0] <= 1'b1; end
            PSO_FN_RETSYS: begin
              sp_o <= usp_q; pc_o <= tmp_q; wb_mask_o[1] <= 1'b1; wb_mask_o[6] <= 1'b1;
            end
            PSO_FN_RTI: if (tmp_q[3]) begin
              sp_o <= usp_q; wb_mask_o[1] <= 1'b1;
            end else begin
              sp_o <= pso_addr(sp_q, PSO_FRAME_LEN); wb_mask_o[1] <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // processor status, stacks, context registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_q <= PSO_PS_RESET; usp_q <= 64'h0; control_block_base_q <= 64'h0; page_table_base_q <= 64'h0;
      old_page_table_base_q <= 64'h0; uniq_q <= 64'h0; fen_o <= 1'b0; asn_o <= 32'h0;
    end else begin
      if (mem_req_o & mem_ack_i & ~mem_we_o & (func_q == PSO_FN_SWPCTX)) begin
        case (step_q)
          4'd6: usp_q <= rd;
          4'd7: begin old_page_table_base_q <= page_table_base_q; page_table_base_q <= rd; end
          4'd8: if (asn_en) asn_o <= rd[63:32];
          4'd9: fen_o <= rd[0];
          4'd10: if (uniq_en) uniq_q <= rd; // reload from the new block
          default: ;
        endcase
      end
      if (state_q == PSO_FINISH && func_q <= PSO_FN_WHAMI && !user_mode) begin
        case (func_q)
          PSO_FN_RETSYS: ps_q <= PSO_PS_USER;
          PSO_FN_RTI: ps_q <= tmp_q[3] ? PSO_PS_USER : {60'h0, tmp_q[3:0]};
          PSO_FN_SWPIPL: ps_q[2:0] <= a0_q[2:0];
          // base switches only at the finish: v0 must still see the old one
          PSO_FN_SWPCTX: control_block_base_q <= a0_q;
          default: ;
        endcase
      end
    end
  end
  // kernel stack pointer past the frame is saved in ksp_q for user-bound returns
  logic [63:0] ksp_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) ksp_q <= 64'h0;
    else if (state_q == PSO_FINISH && !user_mode &&
             (func_q == PSO_FN_RETSYS || (func_q == PSO_FN_RTI && tmp_q[3])))
      ksp_q <= pso_addr(sp_q, PSO_FRAME_LEN);
  end

  // cycle counter with high half rewritten by context swap
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_q <= 64'h0; cyc_smp_q <= 64'h0;
    end else begin
      cyc_q[31:0] <= cyc_q[31:0] + 32'h1;
      if (start) cyc_smp_q <= cyc_q;
      if (mem_req_o & mem_ack_i & ~mem_we_o & (func_q == PSO_FN_SWPCTX) & (step_q == 4'd8))
        cyc_q[63:32] <= rd[31:0] - cyc_smp_q[31:0];
    end
  end

  // pending-interrupt and lock flags: clear on return wins only without a new set
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      intr_flag_o <= 1'b0; lock_flag_o <= 1'b0;
    end else begin
      if (state_q == PSO_FINISH && !user_mode && (func_q == PSO_FN_RETSYS || func_q == PSO_FN_RTI)) begin
        intr_flag_o <= intr_set_i;
        lock_flag_o <= lock_set_i;
      end else begin
        if (intr_set_i) intr_flag_o <= 1'b1;
        if (lock_set_i) lock_flag_o <= 1'b1;
      end
    end
  end

  // translation invalidate commands, one-cycle pulse
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tb_cmd_o <= PSO_TBC_NONE; tb_va_o <= 64'h0;
    end else begin
      tb_cmd_o <= PSO_TBC_NONE;
      if (state_q == PSO_FINISH && !user_mode) begin
        if (func_q == PSO_FN_TBI) begin
          tb_va_o <= a1_q;
          case (a0_q)
            PSO_TBI_I:    tb_cmd_o <= PSO_TBC_I;
            PSO_TBI_D:    tb_cmd_o <= PSO_TBC_D;
            PSO_TBI_BOTH: tb_cmd_o <= PSO_TBC_BOTH;
            PSO_TBI_NG:   tb_cmd_o <= PSO_TBC_NG;
            PSO_TBI_ALL:  tb_cmd_o <= PSO_TBC_ALL;
            default:      tb_cmd_o <= PSO_TBC_NONE;
          endcase
        end else if (func_q == PSO_FN_SWPCTX && !asn_en && old_page_table_base_q != page_table_base_q)
          tb_cmd_o <= PSO_TBC_NG;
      end
    end
  end

  // sticky-free status snapshot for software
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) status_q <= 8'h0;
    else status_q <= {3'h0, halt_o, fault_o, user_mode, lock_flag_o, intr_flag_o};
  end

  pso_apb_regs u_regs (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .prdata_o    (prdata_o),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .ps_i        (ps_q),
    .usp_i       (usp_q),
    .control_block_base_i      (control_block_base_q),
    .page_table_base_i      (page_table_base_q),
    .status_i    (status_q),
    .sysval_o    (sysval),
    .kstack_ok_o (kstack_ok),
    .asn_en_o    (asn_en),
    .uniq_en_o   (uniq_en)
  );
endmodule
`default_nettype wire

/* verification/pso_unit_chk.sv */
// port-level assertions for the privileged state operation unit
`timescale 1ns/10ps
`default_nettype none
module pso_unit_chk
  import pso_pkg::*;
#(
  parameter logic [7:0] CPU_INDEX = 8'h00
)(
  // clock, reset and request
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        op_valid_i,
  input wire logic [5:0]  op_func_i,
  input wire logic [63:0] a0_i,
  // outputs watched
  input wire logic        op_ready_o,
  input wire logic        op_done_o,
  input wire logic        fault_o,
  input wire logic        halt_o,
  input wire logic [63:0] v0_o,
  input wire logic [63:0] ps_o,
  input wire logic        mem_req_o,
  input wire logic        mem_ack_i,
  input wire logic [63:0] mem_addr_o,
  input wire logic [2:0]  tb_cmd_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic       take;
  logic [5:0] fn_q;
  assign take = op_valid_i && op_ready_o;
  // remember the code in flight, completion checks need it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) fn_q <= 6'h00;
    else if (take) fn_q <= op_func_i;
  end
  a_user_fault: assert property (take && ps_o[3] |-> ##2 op_done_o && fault_o)
    else $error("user mode request did not fault");
  a_fault_pairs: assert property (fault_o |-> op_done_o)
    else $error("fault without completion");
  a_status_copy: assert property (take && !ps_o[3] && op_func_i == PSO_FN_RDPS
    |-> ##2 op_done_o && !fault_o && v0_o == $past(ps_o, 2)) else $error("status read wrong");
  a_ipl_swap: assert property (take && !ps_o[3] && op_func_i == PSO_FN_SWPIPL |-> ##2
    v0_o[2:0] == $past(ps_o[2:0], 2) && ps_o[2:0] == $past(a0_i[2:0], 2)) else $error("priority swap wrong");
  a_cpu_index: assert property (take && !ps_o[3] && op_func_i == PSO_FN_WHAMI
    |-> ##2 op_done_o && v0_o == {56'h0, CPU_INDEX}) else $error("processor index wrong");
  a_reserved_code: assert property (take && op_func_i > PSO_FN_WHAMI |-> ##2 op_done_o && fault_o)
    else $error("reserved code did not fault");
  a_done_pulse: assert property (op_done_o |=> !op_done_o)
    else $error("completion longer than one cycle");
  a_sys_return: assert property (op_done_o && !fault_o && fn_q == PSO_FN_RETSYS |-> ps_o == PSO_PS_USER)
    else $error("status after system return wrong");
  a_halt_sticks: assert property (halt_o |=> halt_o && !op_done_o)
    else $error("halt released");
  a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped early");
  a_flush_all: assert property (take && !ps_o[3] && op_func_i == PSO_FN_TBI && a0_i == PSO_TBI_ALL
    |-> ##[1:2] tb_cmd_o == PSO_TBC_ALL) else $error("full flush missing");
endmodule
bind pso_unit pso_unit_chk #(.CPU_INDEX(CPU_INDEX)) pso_unit_chk_i (.core_clk_i, .rst_i, .op_valid_i,
  .op_func_i, .a0_i, .op_ready_o, .op_done_o, .fault_o, .halt_o, .v0_o, .ps_o, .mem_req_o, .mem_ack_i,
  .mem_addr_o, .tb_cmd_o);
`default_nettype wire

/* verification/tb_pso_unit.sv */
// self-checking testbench for the privileged state operation unit
`timescale 1ns/10ps
`default_nettype none
module tb_pso_unit;
  import pso_pkg::*;
  logic        core_clk_i, rst_i, op_valid_i, intr_set_i, lock_set_i, mem_ack_i, psel_i, penable_i, pwrite_i;
  logic        op_ready_o, op_done_o, fault_o, halt_o, intr_flag_o, lock_flag_o, fen_o, mem_req_o;
  logic        mem_we_o, pready_o, pslverr_o, er, g;
  logic [5:0]  op_func_i;
  logic [6:0]  wb_mask_o;
  logic [2:0]  tb_cmd_o, tbc, x, k;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, asn_o, seed, rd;
  logic [63:0] sp_i, a0_i, a1_i, a2_i, gp_i, mem_rdata_i, v0_o, sp_o, gp_o, a0_o, a1_o, a2_o, pc_o;
  logic [63:0] ps_o, mem_addr_o, mem_wdata_o, tb_va_o, s, t, u;
  int          num_errors, comparisons;
  pso_unit pso_unit_i (.*);
  // 125 MHz core clock
  initial begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // memory image: each word derived from its own address
  function automatic logic [63:0] fm(input logic [63:0] a);
    return {~a[31:0], a[31:0]};
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [63:0] gv, input logic [63:0] ev);
    comparisons++;
    if (gv !== ev) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, gv, ev);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rst;
    @(posedge core_clk_i);
    rst_i <= 1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 0;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  // one operation; tb command pulses are caught on the way
  task automatic op(input logic [5:0] f, input logic [63:0] sp, input logic [63:0] a0);
    int n;
    @(posedge core_clk_i);
    op_valid_i <= 1;
    op_func_i <= f;
    sp_i <= sp;
    a0_i <= a0;
    a1_i <= {xs(), xs()};
    gp_i <= {xs(), xs()};
    do @(posedge core_clk_i); while (op_ready_o !== 1'b1);
    op_valid_i <= 0;
    tbc = 0;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (tb_cmd_o != 0) tbc = tb_cmd_o;
    end while (op_done_o !== 1'b1 && n < 80);
    if (op_done_o !== 1'b1 && halt_o !== 1'b1) chk(0, 1);
  endtask
  // memory answers after a varying wait; data is garbage outside the ack
  always @(posedge core_clk_i) begin
    k <= k + 3'h1;
    g = mem_req_o && !mem_ack_i && (k[0] | k[2]);
    mem_ack_i <= g;
    mem_rdata_i <= g ? fm(mem_addr_o) : ~fm(mem_addr_o);
    // saved words: sp at +0, user sp and unique copied from the old block, zero in block 0
    if (g && mem_we_o && mem_addr_o[5:0] != 6'h18)
      chk(mem_wdata_o, (mem_addr_o[5:0] == 6'h0) ? s : (mem_addr_o < 64'h40) ? 64'h0 : fm(mem_addr_o));
  end
  // watchdog well beyond the expected run
  initial begin
    #100000;
    num_errors++;
    print_verdict;
  end
  initial begin
    {rst_i, op_valid_i, intr_set_i, lock_set_i, psel_i, penable_i, pwrite_i, mem_ack_i} = 8'h80;
    {op_func_i, paddr_i, pwdata_i, k} = 0;
    {sp_i, a0_i, a1_i, a2_i, gp_i, mem_rdata_i} = 0;
    seed = 32'h72A8;
    rst;
    op(PSO_FN_RDPS, 0, 0);
    chk(v0_o, PSO_PS_RESET);
    s = {xs(), xs()};
    apb(1, PSO_REG_SYSVAL_LO, s[31:0]);
    apb(1, PSO_REG_SYSVAL_HI, s[63:32]);
    op(PSO_FN_RDVAL, 0, 0);
    chk(v0_o, s);
    apb(0, PSO_REG_SYSVAL_HI, 0);
    chk(rd, s[63:32]);
    apb(0, 12'hFFC, 0);
    chk(er, 1);
    op(PSO_FN_WHAMI, 0, 0);
    chk(v0_o, 0);
    // every priority level, random upper bits in the operand
    for (int i = 0; i < 8; i++) begin
      u = ps_o;
      s = {xs(), xs()};
      s[2:0] = i[2:0];
      op(PSO_FN_SWPIPL, 0, s);
      chk(v0_o[2:0], u[2:0]);
      chk(ps_o[2:0], s[2:0]);
    end
    // every invalidate selector plus unused ones
    for (int i = -2; i < 5; i++) begin
      x = (i > 0 && i < 4) ? i[2:0] : (i == -1) ? PSO_TBC_NG : (i == -2) ? PSO_TBC_ALL : PSO_TBC_NONE;
      op(PSO_FN_TBI, 0, 64'(i));
      chk(tbc, x);
      chk(tb_va_o, a1_i);
    end
    op(6'h3F, 0, 0);
    chk(fault_o, 1);
    // kernel-to-kernel exception return with pending flags set
    @(posedge core_clk_i);
    {intr_set_i, lock_set_i} <= 2'b11;
    @(posedge core_clk_i);
    {intr_set_i, lock_set_i} <= 2'b00;
    s = {xs(), xs()} & 64'hFFFF_FFFF_FFFF_FFF0;
    op(PSO_FN_RTI, s, 0);
    chk(ps_o, 0);
    chk(pc_o, fm(s + 8));
    chk(a2_o, fm(s + 40));
    chk(a0_o, fm(s + 24));
    chk(wb_mask_o, 7'h7E);
    chk(sp_o, s + 48);
    chk({intr_flag_o, lock_flag_o}, 0);
    // two context swaps so the old base is known
    t = {xs(), xs()} & 64'hFFFF_FFFF_FFFF_FFC0;
    u = t + 64'h1000;
    op(PSO_FN_SWPCTX, s, t);
    op(PSO_FN_SWPCTX, s, u);
    chk(v0_o, t);
    chk(sp_o, fm(u));
    chk(fen_o, fm(u + 40) & 1);
    chk(tbc, PSO_TBC_NG);
    op(PSO_FN_RDUSP, 0, 0);
    chk(v0_o, fm(u + 8));
    op(PSO_FN_RETSYS, s, 0);
    chk(pc_o, fm(s + 8));
    chk(gp_o, fm(s + 16));
    chk(sp_o, fm(u + 8));
    chk(ps_o, PSO_PS_USER);
    op(PSO_FN_RDPS, 0, 0);
    chk(fault_o, 1);
    rst;
    // invalid kernel stack: return halts instead of completing
    apb(1, PSO_REG_CTRL, 32'h4);
    op(PSO_FN_RETSYS, s, 0);
    chk(halt_o, 1);
    rst;
    op(PSO_FN_RDPS, 0, 0);
    chk(v0_o, PSO_PS_RESET);
    // user-bound exception return: popped status has bit 3 set
    op(PSO_FN_RTI, s | 64'h8, 0);
    chk(ps_o, PSO_PS_USER);
    chk(sp_o, 0);
    print_verdict;
  end
endmodule
`default_nettype wire
